// file: src/cira_pkg.sv
// Purpose: Shared constants and carriers for the indexed CAN register block.
// Assumes: 8-bit host register bus, 16-bit CAN register words.
// Notes: Host addresses of index and high data window are local choices.
package cira_pkg;
  // Host register addresses.
  localparam logic [7:0] SFR_CTRL = 8'hf8;
  localparam logic [7:0] SFR_STAT = 8'hc0;
  localparam logic [7:0] SFR_TEST = 8'hdb;
  localparam logic [7:0] SFR_DATA_LOW = 8'hd8;
  localparam logic [7:0] SFR_DATA_HIGH = 8'hd9;
  localparam logic [7:0] SFR_INDEX = 8'hda;
  // Index numbers of the CAN register space.
  localparam logic [6:0] IDX_CTRL = 7'h00;
  localparam logic [6:0] IDX_STAT = 7'h01;
  localparam logic [6:0] IDX_ERR = 7'h02;
  localparam logic [6:0] IDX_BT = 7'h03;
  localparam logic [6:0] IDX_INTR = 7'h04;
  localparam logic [6:0] IDX_TEST = 7'h05;
  localparam logic [6:0] IDX_PRESCALER_EXTENSION_FIELD = 7'h06;
  localparam logic [6:0] IDX_IF1 = 7'h08;
  localparam logic [6:0] IDX_IF2 = 7'h20;
  localparam logic [6:0] IDX_TXREQ1 = 7'h40;
  localparam logic [6:0] IDX_TXREQ2 = 7'h41;
  localparam logic [6:0] IDX_NEWDAT1 = 7'h48;
  localparam logic [6:0] IDX_NEWDAT2 = 7'h49;
  localparam logic [6:0] IDX_INTPND1 = 7'h50;
  localparam logic [6:0] IDX_INTPND2 = 7'h51;
  localparam logic [6:0] IDX_VALID1 = 7'h58;
  localparam logic [6:0] IDX_VALID2 = 7'h59;
  // Interface set layout: words per set and word offsets.
  localparam logic [6:0] IF_WORDS = 7'h0b;
  localparam int IF_N = 11;
  localparam int IF_CMDREQ = 0;
  localparam int IF_CMDMASK = 1;
  localparam int IF_XFER_FIRST = 2;
  localparam int IF_XFER_N = 9;
  localparam int OBJ_COUNT = 32;
  localparam logic [5:0] OBJ_MAX = 6'h20;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [15:0] BT_RST = 16'h2301;
  localparam logic [3:0] PRESCALER_EXTENSION_FIELD_RST = 4'h0;
  localparam logic [15:0] CMDREQ_RST = 16'h0001;
  localparam logic [15:0] MASK_RST = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Bit positions.
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CCE_BIT = 6;
  localparam int CTRL_TEST_BIT = 7;
  localparam int TEST_RX_BIT = 7;
  localparam int CMDMASK_WR_BIT = 7;
  // Bit-timing word fields: weights 0x1000, 0x0100, 0x0040 and 1.
  localparam int BT_SECOND_PHASE_FIELD_LSB = 12;
  localparam int BT_FIRST_SEGMENT_FIELD_LSB = 8;
  localparam int BT_SJW_LSB = 6;
  localparam int BT_BRP_LSB = 0;
  // Fixed synchronisation segment, in quanta.
  localparam logic [6:0] SYNC_SEG_TQ = 7'h01;

  // One host bus request, valid for one cycle.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } cira_sfr_req_s;

  // Per-object flags from the message handler.
  typedef struct packed {
    logic [31:0] txreq;
    logic [31:0] newdat;
    logic [31:0] intpnd;
    logic [31:0] object_valid_flags;
  } cira_mh_flags_s;

  // Decoded bit-timing fields, each holding its length minus one, except baud_prescaler, which holds the prescaler itself.
  typedef struct packed {
    logic [2:0] second_phase_field;
    logic [3:0] first_segment_field;
    logic [1:0] jump_width_field;
    logic [5:0] prescaler_extension_field;
    logic [4:0] baud_prescaler;
  } cira_timing_s;

  // Reset value of one interface word by offset.
  function automatic logic [15:0] if_word_reset(input int w);
    if (w == IF_CMDREQ) return CMDREQ_RST;
    if (w == IF_XFER_FIRST || w == IF_XFER_FIRST + 1) return MASK_RST;
    return WORD_RST;
  endfunction
endpackage

// file: src/cira_bit_timing.sv
// Purpose: Decodes the bit-timing word and paces quanta and bit segments.
// Assumes: Runs only while the controller is out of initialisation.
// Notes: Quantum pulse comes from a divider on core_clk.
`timescale 1ns/10ps
`default_nettype none
module cira_bit_timing (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Configuration.
  input wire logic [15:0] bt_word,
  input wire logic [3:0] ext_reg,
  input wire logic run,
  // Timing results.
  output cira_pkg::cira_timing_s timing,
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point
);
  logic [4:0] div_q; // Clocks elapsed in the current quantum.
  logic [6:0] seg_q; // Quantum number inside the bit.
  logic tick;
  logic [6:0] bit_len;
  logic [6:0] sample_tq;

  // Field decode by weight.
  assign timing.second_phase_field = bt_word[cira_pkg::BT_SECOND_PHASE_FIELD_LSB +: 3];
  assign timing.first_segment_field = bt_word[cira_pkg::BT_FIRST_SEGMENT_FIELD_LSB +: 4];
  assign timing.jump_width_field = bt_word[cira_pkg::BT_SJW_LSB +: 2];
  assign timing.prescaler_extension_field = bt_word[cira_pkg::BT_BRP_LSB +: 6];
  assign timing.baud_prescaler = {1'b0, ext_reg} + 5'h01;

  // One quantum ends after baud_prescaler clocks.
  assign tick = run && (div_q == timing.baud_prescaler - 5'h01);
  // Sync plus first segment plus second phase make the bit.
  assign bit_len = cira_pkg::SYNC_SEG_TQ + {3'h0, timing.first_segment_field} + 7'h01
                 + {4'h0, timing.second_phase_field} + 7'h01;
  assign sample_tq = cira_pkg::SYNC_SEG_TQ + {3'h0, timing.first_segment_field};

  // Divider and segment counter; both park at zero while halted.
  always_ff @(posedge core_clk) begin
    if (!rstn || !run) begin
      div_q <= 5'h00;
      seg_q <= 7'h00;
    end else begin
      div_q <= tick ? 5'h00 : div_q + 5'h01;
      if (tick) begin
        seg_q <= (seg_q == bit_len - 7'h01) ? 7'h00 : seg_q + 7'h01;
      end
    end
  end

  // Registered pulses so tq_tick, bit_start and sample_point come from flops.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tq_tick <= 1'b0;
      bit_start <= 1'b0;
      sample_point <= 1'b0;
    end else begin
      tq_tick <= tick;
      bit_start <= tick && seg_q == 7'h00;
      sample_point <= tick && seg_q == sample_tq;
    end
  end
endmodule
`default_nettype wire

// file: src/cira_msg_store.sv
// Purpose: Message object storage reached through interface set transfers.
// Assumes: At most one transfer request per cycle.
// Notes: A read answers one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
module cira_msg_store #(
  parameter int OBJS = 32,
  parameter int WORDS = 9
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Transfer request.
  input wire logic go,
  input wire logic to_ram,
  input wire logic [4:0] obj,
  input wire logic [WORDS*16-1:0] wwords,
  // Read answer.
  output logic [WORDS*16-1:0] rwords,
  output logic done
);
  logic [WORDS*16-1:0] mem_q [OBJS]; // One flop row per message object.

  // Writes store the whole object; reads fetch it for the interface set.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < OBJS; i++) begin
        mem_q[i] <= '0;
      end
      rwords <= '0;
      done <= 1'b0;
    end else begin
      done <= go && !to_ram;
      if (go && to_ram) begin
        mem_q[obj] <= wwords;
      end
      if (go && !to_ram) begin
        rwords <= mem_q[obj];
      end
    end
  end
endmodule
`default_nettype wire

// file: src/cira_top.sv
// Purpose: Host access to the CAN register space by index and data window.
// Assumes: One host access per cycle; strobes count only with page hit.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module cira_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Host register bus.
  input wire logic register_page_hit,
  input wire cira_pkg::cira_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // Protocol core side.
  input wire logic can_rx_pin,
  input wire logic [7:0] core_status_set,
  input wire logic [15:0] core_error,
  input wire logic [15:0] core_interrupt,
  input wire cira_pkg::cira_mh_flags_s mh_flags,
  // Timing results.
  output logic init_mode,
  output cira_pkg::cira_timing_s timing,
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point
);
  localparam int XW = cira_pkg::IF_XFER_N * 16;

  // Index in an interface set window starting at base.
  function automatic logic if_hit(input logic [6:0] idx, input logic [6:0] base);
    return idx >= base && idx < base + cira_pkg::IF_WORDS;
  endfunction

  logic [6:0] index_q; // Selected word of the CAN space.
  logic [7:0] data_high_q; // Staged or captured upper byte.
  logic [7:0] ctrl_q; // Control register.
  logic [7:0] status_q; // Status register.
  logic [7:0] test_q; // Test register, bit 7 unused here.
  logic [15:0] bt_q; // Bit-timing register.
  logic [3:0] prescaler_extension_field_q; // Prescaler extension register.
  logic [7:0] rdata_q; // Registered read answer.
  logic rx_s1, rx_s2, rx_s3, rx_q; // Receive pin synchroniser.
  logic xfer_set_q; // Set waiting for a read answer.

  // Strobe decode, gated by the register page.
  logic acc_wr, acc_rd;
  logic wr_low, rd_low, bit_low, wr_high, wr_index;
  logic wr_ctrl, wr_stat, wr_test;
  assign acc_wr = register_page_hit && sfr_req.wr;
  assign acc_rd = register_page_hit && sfr_req.rd;
  assign wr_low = acc_wr && sfr_req.addr == cira_pkg::SFR_DATA_LOW;
  assign rd_low = acc_rd && sfr_req.addr == cira_pkg::SFR_DATA_LOW;
  assign bit_low = register_page_hit && sfr_req.bit_wr;
  assign wr_high = acc_wr && sfr_req.addr == cira_pkg::SFR_DATA_HIGH;
  assign wr_index = acc_wr && sfr_req.addr == cira_pkg::SFR_INDEX;
  assign wr_ctrl = acc_wr && sfr_req.addr == cira_pkg::SFR_CTRL;
  assign wr_stat = acc_wr && sfr_req.addr == cira_pkg::SFR_STAT;
  assign wr_test = acc_wr && sfr_req.addr == cira_pkg::SFR_TEST;

  // Interface set words, flattened per set.
  logic [cira_pkg::IF_N*16-1:0] if_flat [2];
  logic [6:0] if_off [2];
  logic in_set [2];
  logic [XW-1:0] rwords;
  logic rd_done;

  // Word currently selected by the index.
  logic [7:0] test_rd;
  logic [15:0] idx_rdata;
  assign test_rd = {rx_q, test_q[cira_pkg::TEST_RX_BIT-1:0]};
  always_comb begin
    idx_rdata = 16'h0000; // Unmapped index reads as zero.
    if (in_set[0]) begin
      idx_rdata = if_flat[0][{if_off[0][3:0], 4'h0} +: 16];
    end else if (in_set[1]) begin
      idx_rdata = if_flat[1][{if_off[1][3:0], 4'h0} +: 16];
    end else begin
      case (index_q)
        cira_pkg::IDX_CTRL: idx_rdata = {8'h00, ctrl_q};
        cira_pkg::IDX_STAT: idx_rdata = {8'h00, status_q};
        cira_pkg::IDX_ERR: idx_rdata = core_error;
        cira_pkg::IDX_BT: idx_rdata = bt_q;
        cira_pkg::IDX_INTR: idx_rdata = core_interrupt;
        cira_pkg::IDX_TEST: idx_rdata = {8'h00, test_rd};
        cira_pkg::IDX_PRESCALER_EXTENSION_FIELD: idx_rdata = {12'h000, prescaler_extension_field_q};
        // Message handler flags: only reachable here, never written.
        cira_pkg::IDX_TXREQ1: idx_rdata = mh_flags.txreq[15:0];
        cira_pkg::IDX_TXREQ2: idx_rdata = mh_flags.txreq[31:16];
        cira_pkg::IDX_NEWDAT1: idx_rdata = mh_flags.newdat[15:0];
        cira_pkg::IDX_NEWDAT2: idx_rdata = mh_flags.newdat[31:16];
        cira_pkg::IDX_INTPND1: idx_rdata = mh_flags.intpnd[15:0];
        cira_pkg::IDX_INTPND2: idx_rdata = mh_flags.intpnd[31:16];
        cira_pkg::IDX_VALID1: idx_rdata = mh_flags.object_valid_flags[15:0];
        cira_pkg::IDX_VALID2: idx_rdata = mh_flags.object_valid_flags[31:16];
        default: idx_rdata = 16'h0000;
      endcase
    end
  end

  // One write path serves the data window, bit writes and direct maps.
  // Direct maps land on the same index so both views share storage.
  logic wr_go;
  logic [6:0] wr_idx;
  logic [15:0] wr_word;
  always_comb begin
    logic [7:0] low_mod;
    low_mod = idx_rdata[7:0];
    low_mod[sfr_req.bit_sel] = sfr_req.bit_val;
    wr_go = 1'b1;
    wr_idx = index_q;
    wr_word = {data_high_q, sfr_req.wdata};
    if (wr_low) begin
      wr_idx = index_q; // Commit of the staged high byte.
    end else if (bit_low) begin
      wr_word = {data_high_q, low_mod};
    end else if (wr_ctrl) begin
      wr_idx = cira_pkg::IDX_CTRL;
      wr_word = {8'h00, sfr_req.wdata};
    end else if (wr_stat) begin
      wr_idx = cira_pkg::IDX_STAT;
      wr_word = {8'h00, sfr_req.wdata};
    end else if (wr_test) begin
      wr_idx = cira_pkg::IDX_TEST;
      wr_word = {8'h00, sfr_req.wdata};
    end else begin
      wr_go = 1'b0;
    end
  end

  // Per-target write hits.
  logic w_ctrl, w_stat, w_test, w_bt, w_prescaler_extension_field, low_access;
  assign w_ctrl = wr_go && wr_idx == cira_pkg::IDX_CTRL;
  assign w_stat = wr_go && wr_idx == cira_pkg::IDX_STAT;
  assign w_test = wr_go && wr_idx == cira_pkg::IDX_TEST;
  assign w_bt = wr_go && wr_idx == cira_pkg::IDX_BT && ctrl_q[cira_pkg::CTRL_CCE_BIT];
  assign w_prescaler_extension_field = wr_go && wr_idx == cira_pkg::IDX_PRESCALER_EXTENSION_FIELD && ctrl_q[cira_pkg::CTRL_TEST_BIT];
  assign low_access = wr_low || rd_low || bit_low;

  // Transfer requests from either set's command request word.
  logic [1:0] go_set;
  logic [5:0] obj_num;
  assign obj_num = wr_word[5:0];

  // Both interface sets share one structure, differing in base index.
  for (genvar s = 0; s < 2; s++) begin : g_set
    localparam logic [6:0] BASE = (s == 0) ? cira_pkg::IDX_IF1 : cira_pkg::IDX_IF2;
    logic [15:0] wq [cira_pkg::IF_N]; // Words of this set.
    logic hit_w;
    logic [6:0] wr_off;
    assign in_set[s] = if_hit(index_q, BASE);
    assign if_off[s] = index_q - BASE;
    assign hit_w = wr_go && if_hit(wr_idx, BASE);
    assign wr_off = wr_idx - BASE;
    // Object numbers run 1 to 32; others start no transfer.
    assign go_set[s] = hit_w && wr_off == 7'(cira_pkg::IF_CMDREQ)
                       && obj_num != 6'h00 && obj_num <= cira_pkg::OBJ_MAX;
    for (genvar w = 0; w < cira_pkg::IF_N; w++) begin : g_word
      assign if_flat[s][w*16 +: 16] = wq[w];
      // Clamped so the two front words never form a negative part-select.
      localparam int RW = (w >= cira_pkg::IF_XFER_FIRST) ? w - cira_pkg::IF_XFER_FIRST : 0;
      // Host writes, or a read answer loads the object words.
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          wq[w] <= cira_pkg::if_word_reset(w);
        end else if (rd_done && xfer_set_q == 1'(s) && w >= cira_pkg::IF_XFER_FIRST) begin
          wq[w] <= rwords[RW*16 +: 16];
        end else if (hit_w && wr_off == 7'(w)) begin
          wq[w] <= wr_word;
        end
      end
    end
  end

  // Transfer source is the requesting set.
  logic go, to_ram, xset;
  logic [XW-1:0] wwords;
  assign go = |go_set;
  assign xset = go_set[1];
  assign wwords = if_flat[xset][cira_pkg::IF_N*16-1 : cira_pkg::IF_XFER_FIRST*16];
  assign to_ram = if_flat[xset][cira_pkg::IF_CMDMASK*16 + cira_pkg::CMDMASK_WR_BIT];

  cira_msg_store #(
    .OBJS(cira_pkg::OBJ_COUNT),
    .WORDS(cira_pkg::IF_XFER_N)
  ) u_store (
    .core_clk(core_clk),
    .rstn(rstn),
    .go(go),
    .to_ram(to_ram),
    .obj(5'(obj_num - 6'h01)),
    .wwords(wwords),
    .rwords(rwords),
    .done(rd_done)
  );

  // Protocol registers; status events win over a host write.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_q <= cira_pkg::CTRL_RST;
      status_q <= cira_pkg::STAT_RST;
      test_q <= cira_pkg::TEST_RST;
      bt_q <= cira_pkg::BT_RST;
      prescaler_extension_field_q <= cira_pkg::PRESCALER_EXTENSION_FIELD_RST;
      xfer_set_q <= 1'b0;
    end else begin
      if (w_ctrl) ctrl_q <= wr_word[7:0];
      status_q <= (w_stat ? wr_word[7:0] : status_q) | core_status_set;
      if (w_test) test_q <= wr_word[7:0];
      if (w_bt) bt_q <= wr_word;
      if (w_prescaler_extension_field) prescaler_extension_field_q <= wr_word[3:0];
      if (go) xfer_set_q <= xset;
    end
  end

  // Index register with stepping inside the interface sets.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      index_q <= 7'h00;
    end else if (wr_index) begin
      index_q <= sfr_req.wdata[6:0];
    end else if (low_access && (in_set[0] || in_set[1])) begin
      index_q <= index_q + 7'h01;
    end
  end

  // Upper byte: staged by a host write, captured by a low read.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      data_high_q <= 8'h00;
    end else if (wr_high) begin
      data_high_q <= sfr_req.wdata;
    end else if (rd_low) begin
      data_high_q <= idx_rdata[15:8];
    end
  end

  // Host read mux; unmapped addresses answer zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr_req.addr)
      cira_pkg::SFR_DATA_LOW: rd_mux = idx_rdata[7:0];
      cira_pkg::SFR_DATA_HIGH: rd_mux = data_high_q;
      cira_pkg::SFR_INDEX: rd_mux = {1'b0, index_q};
      cira_pkg::SFR_CTRL: rd_mux = ctrl_q;
      cira_pkg::SFR_STAT: rd_mux = status_q;
      cira_pkg::SFR_TEST: rd_mux = test_rd;
      default: rd_mux = 8'h00;
    endcase
  end

  // Answer is held until the next read.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (acc_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Receive pin: three flops, a change counts when the last two agree.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      rx_s1 <= can_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_q <= rx_s3;
    end
  end

  // Bit timing runs only outside initialisation, as the host configures
  // it while init is set.
  cira_bit_timing u_timing (
    .core_clk(core_clk),
    .rstn(rstn),
    .bt_word(bt_q),
    .ext_reg(prescaler_extension_field_q),
    .run(!ctrl_q[cira_pkg::CTRL_INIT_BIT]),
    .timing(timing),
    .tq_tick(tq_tick),
    .bit_start(bit_start),
    .sample_point(sample_point)
  );

  assign sfr_rdata = rdata_q;
  assign init_mode = ctrl_q[cira_pkg::CTRL_INIT_BIT];
endmodule
`default_nettype wire

// file: sim/cira_monitor.sv
// Purpose: Concurrent checks on the indexed register block's ports.
// Assumes: One host access per cycle, strobes qualified by register_page_hit.
// Notes: Bound into every cira_top instance by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module cira_monitor (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Host register bus.
  input wire logic register_page_hit,
  input wire cira_pkg::cira_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  // Timing results.
  input wire logic init_mode,
  input wire cira_pkg::cira_timing_s timing,
  input wire logic tq_tick
);
  // Qualified strobes, as the block sees them.
  wire logic rd_hit = register_page_hit && sfr_req.rd;
  wire logic wr_hit = register_page_hit && (sfr_req.wr || sfr_req.bit_wr);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Read data is held until the next qualified read.
  property p_rdata_hold; !rd_hit |=> $stable(sfr_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  // A direct control write shows on init_mode one cycle later.
  property p_ctrl_write; wr_hit && sfr_req.wr && sfr_req.addr == cira_pkg::SFR_CTRL
    |=> init_mode == $past(sfr_req.wdata[0]); endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not seen on init_mode");
  // A direct control read returns the init bit.
  property p_ctrl_read; rd_hit && sfr_req.addr == cira_pkg::SFR_CTRL |=> sfr_rdata[0] == init_mode; endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read disagrees with init_mode");
  // Quanta stand still while in initialisation.
  property p_halt_in_init; init_mode && $past(init_mode) |-> !tq_tick; endproperty
  a_halt_in_init: assert property (p_halt_in_init) else $error("quantum tick during init");
  // With a prescaler of two, ticks come every second clock.
  property p_tq_spacing; tq_tick && !init_mode && timing.baud_prescaler == 5'h02
    |=> !tq_tick ##1 (tq_tick || init_mode); endproperty
  a_tq_spacing: assert property (p_tq_spacing) else $error("quantum spacing wrong");
  // Timing fields only change after a write.
  property p_timing_stable; !wr_hit |=> $stable(timing); endproperty
  a_timing_stable: assert property (p_timing_stable) else $error("timing changed without a write");
  // An unmapped host address reads zero.
  property p_unmapped_zero; rd_hit && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped address read nonzero");
  // Without the page hit read data, init_mode and timing stay unchanged.
  property p_page_gate; !register_page_hit |=> $stable(sfr_rdata) && $stable(init_mode) && $stable(timing); endproperty
  a_page_gate: assert property (p_page_gate) else $error("access taken without page hit");
endmodule
bind cira_top cira_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .register_page_hit(register_page_hit),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .init_mode(init_mode), .timing(timing), .tq_tick(tq_tick));
`default_nettype wire

// file: sim/cira_host_model.sv
// Purpose: Processor core model driving the host register bus.
// Assumes: Strobes are raised at a falling edge and taken at the next rising edge.
// Notes: Each access takes two cycles, which keeps every signal single-assigned per step.
`timescale 1ns/10ps
`default_nettype none
module cira_host_model (
  // Clock.
  input wire logic core_clk,
  // Host register bus.
  output var logic page_hit,
  output var cira_pkg::cira_sfr_req_s req,
  input wire logic [7:0] rdata
);
  // Idle bus with the controller page selected from time zero.
  initial begin
    page_hit = 1'b1;
    req = '0;
  end
  // One access; the request is dropped only after its taking edge.
  task automatic access(input cira_pkg::cira_sfr_req_s r, input logic pg);
    @(negedge core_clk);
    req = r;
    page_hit = pg;
    @(negedge core_clk);
    req = '0;
    page_hit = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pg = 1'b1);
    access('{addr: a, wdata: d, wr: 1'b1, default: '0}, pg);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    access('{addr: a, rd: 1'b1, default: '0}, 1'b1);
    d = rdata;
  endtask
  task automatic bwr(input logic [2:0] s, input logic v);
    access('{bit_wr: 1'b1, bit_sel: s, bit_val: v, default: '0}, 1'b1);
  endtask
  // High byte is staged first, the low write commits the word.
  task automatic wr16(input logic [6:0] i, input logic [15:0] v);
    wr(cira_pkg::SFR_INDEX, {1'b0, i});
    wr(cira_pkg::SFR_DATA_HIGH, v[15:8]);
    wr(cira_pkg::SFR_DATA_LOW, v[7:0]);
  endtask
  // Low read first, so the upper byte is captured consistently.
  task automatic rd16(input logic [6:0] i, output logic [15:0] v);
    wr(cira_pkg::SFR_INDEX, {1'b0, i});
    rd(cira_pkg::SFR_DATA_LOW, v[7:0]);
    rd(cira_pkg::SFR_DATA_HIGH, v[15:8]);
  endtask
endmodule
`default_nettype wire

// file: sim/can_indexed_register_access_tb.sv
// Purpose: Directed bench for indexed and direct register access and bit pacing.
// Assumes: 25 MHz core clock, inputs driven at falling edges.
// Notes: Status, error and interrupt inputs are tied; only the status storage is exercised, through host writes.
`timescale 1ns/10ps
`default_nettype none
module can_indexed_register_access_tb;
  logic core_clk = 1'b0;
  logic rstn;
  logic page;
  cira_pkg::cira_sfr_req_s req;
  logic [7:0] rdata;
  logic [7:0] b;
  logic [15:0] w;
  cira_pkg::cira_mh_flags_s mh_flags;
  logic init_mode;
  cira_pkg::cira_timing_s timing;
  logic tq_tick;
  logic bit_start;
  logic sample_point;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  // Free running clock, 40 ns period.
  always #20 core_clk = ~core_clk;
  cira_top DUT (.core_clk(core_clk), .rstn(rstn), .register_page_hit(page), .sfr_req(req), .sfr_rdata(rdata),
    .can_rx_pin(1'b1), .core_status_set(8'h00), .core_error(16'h0000), .core_interrupt(16'h0000),
    .mh_flags(mh_flags), .init_mode(init_mode), .timing(timing), .tq_tick(tq_tick), .bit_start(bit_start),
    .sample_point(sample_point));
  cira_host_model host (.core_clk(core_clk), .page_hit(page), .req(req), .rdata(rdata));
  // Closing report, reached from the end of the sequence or a timeout.
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One compare for every register word, field group and cycle count.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Counts cycles until bit_start or sample_point; a bound of 200 cuts a hang.
  task automatic measure(input logic sp, output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 200) begin
        n_errors++;
        finish_test();
      end
    end while (!(sp ? sample_point : bit_start));
  endtask
  initial begin
    rstn = 1'b0;
    mh_flags = '0;
    mh_flags.object_valid_flags = 32'h1234_5678;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    host.rd(cira_pkg::SFR_CTRL, b);
    chk("ctrl", 16'h0001, {8'h00, b});
    host.rd16(cira_pkg::IDX_BT, w);
    chk("bt reset", 16'h2301, w);
    // Without change enable the write must be dropped.
    host.wr16(cira_pkg::IDX_BT, 16'h5ec0);
    host.rd16(cira_pkg::IDX_BT, w);
    chk("bt locked", 16'h2301, w);
    // Init, change enable and test bit set before configuring; 9+6 quanta cover the delay, phases equal.
    host.wr(cira_pkg::SFR_CTRL, 8'hc1);
    host.rd16(cira_pkg::IDX_CTRL, w);
    chk("ctrl idx", 16'h00c1, w);
    host.wr16(cira_pkg::IDX_BT, 16'h5ec0);
    host.rd16(cira_pkg::IDX_BT, w);
    chk("bt", 16'h5ec0, w);
    chk("fields", 16'h5ec0, {1'b0, timing.second_phase_field, timing.first_segment_field,
      timing.jump_width_field, timing.prescaler_extension_field});
    host.bwr(3'h1, 1'b1);
    host.rd16(cira_pkg::IDX_BT, w);
    chk("bt bit", 16'h5ec2, w);
    host.wr16(cira_pkg::IDX_PRESCALER_EXTENSION_FIELD, 16'h0001);
    chk("prescaler", 16'h0002, {11'h000, timing.baud_prescaler});
    // Test bit off: extension writes are ignored.
    host.wr(cira_pkg::SFR_CTRL, 8'h41);
    host.wr16(cira_pkg::IDX_PRESCALER_EXTENSION_FIELD, 16'h0003);
    chk("prescaler locked", 16'h0002, {11'h000, timing.baud_prescaler});
    host.wr(cira_pkg::SFR_CTRL, 8'h00, 1'b0);
    host.rd(cira_pkg::SFR_CTRL, b);
    chk("page gate", 16'h0041, {8'h00, b});
    host.wr16(cira_pkg::IDX_VALID1, 16'h0000);
    host.rd16(cira_pkg::IDX_VALID1, w);
    chk("valid1", 16'h5678, w);
    host.rd16(cira_pkg::IDX_VALID2, w);
    chk("valid2", 16'h1234, w);
    host.wr16(7'h12, 16'h0000);
    host.rd(cira_pkg::SFR_INDEX, b);
    chk("index step", 16'h0013, {8'h00, b});
    // Object 5 stored from set one, then loaded into set two.
    host.wr16(7'h0f, 16'hbeef);
    host.wr16(7'h09, 16'h0080);
    host.wr16(cira_pkg::IDX_IF1, 16'h0005);
    host.wr16(7'h21, 16'h0000);
    host.wr16(cira_pkg::IDX_IF2, 16'h0005);
    host.rd16(7'h27, w);
    chk("if2 data", 16'hbeef, w);
    host.rd16(7'h22, w);
    chk("if2 mask", 16'hffff, w);
    host.rd(8'h00, b);
    chk("unmapped", 16'h0000, {8'h00, b});
    host.rd16(7'h07, w);
    chk("unmapped idx", 16'h0000, w);
    // Status and test share storage between the direct and indexed views.
    host.wr(cira_pkg::SFR_STAT, 8'h5a);
    host.rd16(cira_pkg::IDX_STAT, w);
    chk("stat idx", 16'h005a, w);
    // The receive bit reads the idle pin level, the rest what was written.
    host.wr16(cira_pkg::IDX_TEST, 16'h0003);
    host.rd(cira_pkg::SFR_TEST, b);
    chk("test", 16'h0083, {8'h00, b});
    // Leave init: 22 quanta of 2 clocks per bit, sample after 15 quanta.
    host.wr(cira_pkg::SFR_CTRL, 8'h00);
    chk("init", 16'h0000, {15'h0000, init_mode});
    measure(1'b0, n);
    measure(1'b1, n);
    chk("sample", 16'h001e, 16'(n));
    measure(1'b0, n);
    measure(1'b0, n);
    chk("bit", 16'h002c, 16'(n));
    finish_test();
  end
endmodule
`default_nettype wire
